/* hw/cub_cfg.svh */
// constants of the current unbalance protection block
`ifndef CUB_CFG_SVH
`define CUB_CFG_SVH

// ---------------------------------------------------------------
// percentage arithmetic
// ---------------------------------------------------------------
`define CUB_PCT_SCALE    7'd100
`define CUB_SUFF_NUM     7'd10
`define CUB_NF_MAX_MUL   2'd2
`define CUB_NF_RATED_MUL 2'd3

// ---------------------------------------------------------------
// settings: ranges and defaults
// ---------------------------------------------------------------
`define CUB_PCT_MIN      7'd10
`define CUB_PCT_MAX      7'd90
`define CUB_PCT_DEF      7'd50
`define CUB_DLY_MIN      16'd100
`define CUB_DLY_MAX      16'd60000
`define CUB_DLY_DEF      16'd1000
`define CUB_OPER_DEF     1'b0
`define CUB_SONLY_DEF    1'b0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CUB_CLK_NS       10
`define CUB_MS_NS        1000000
`define CUB_LAT_CYC      2

`endif

/* hw/cub_pkg.sv */
// types of the current unbalance protection block
package cub_pkg;

  typedef enum logic [1:0] {
    CUB_IDLE,
    CUB_TIMING,
    CUB_TRIPPED
  } cub_state_t;

  typedef logic [6:0]  cub_pct_t;
  typedef logic [15:0] cub_ms_t;

endpackage : cub_pkg

/* hw/cub_lvl_if.sv */
// level flags passed from the analogue stage to the decision logic
interface cub_lvl_if;
  logic unbalFlag;
  logic sufficientLevelFlag;
  logic nonFaultLevelFlag;

  modport producer (output unbalFlag, sufficientLevelFlag,
                    nonFaultLevelFlag);
  modport consumer (input  unbalFlag, sufficientLevelFlag,
                    nonFaultLevelFlag);
endinterface : cub_lvl_if

/* hw/cub_level.sv */
// analogue signal processing: max, min and level comparisons
`include "cub_cfg.svh"
module cub_level
  import cub_pkg::*;
#(
  parameter int CUR_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [CUR_W-1:0] phase1RmsCurrent,
  input  wire logic [CUR_W-1:0] phase2RmsCurrent,
  input  wire logic [CUR_W-1:0] phase3RmsCurrent,
  input  wire logic [CUR_W-1:0] ratedCurrent,
  input  wire cub_pct_t         startPct,
  cub_lvl_if.producer           lvl
);
  localparam int PW = CUR_W + 8;

  function automatic logic [CUR_W-1:0] pick(input logic [CUR_W-1:0] a,
                                            input logic [CUR_W-1:0] b,
                                            input logic             big);
    if (big) begin
      pick = (a > b) ? a : b;
    end else begin
      pick = (a < b) ? a : b;
    end
  endfunction : pick

  logic [CUR_W-1:0] curMax;
  logic [CUR_W-1:0] curMin;
  logic [PW-1:0]    diffScaled;
  logic [PW-1:0]    limScaled;
  logic [PW-1:0]    maxWide;
  logic [PW-1:0]    ratedWide;
  logic             unbalD, suffD, nfD;
  logic             unbalQ, suffQ, nfQ;

  // ---------------------------------------------------------------
  // comparisons, done in products so no divider is needed
  // ---------------------------------------------------------------
  always_comb begin
    curMax = pick(pick(phase1RmsCurrent, phase2RmsCurrent, 1'b1),
                  phase3RmsCurrent, 1'b1);
    curMin = pick(pick(phase1RmsCurrent, phase2RmsCurrent, 1'b0),
                  phase3RmsCurrent, 1'b0);
    // widen before multiplying: the products do not fit in CUR_W
    maxWide    = PW'(curMax);
    ratedWide  = PW'(ratedCurrent);
    diffScaled = PW'(curMax - curMin) * PW'(`CUB_PCT_SCALE);
    limScaled  = maxWide * PW'(startPct);
    unbalD = diffScaled > limScaled;
    suffD  = maxWide * PW'(`CUB_SUFF_NUM) > ratedWide;
    nfD    = maxWide * PW'(`CUB_NF_MAX_MUL)
             < ratedWide * PW'(`CUB_NF_RATED_MUL);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unbalQ <= 1'b0;
      suffQ  <= 1'b0;
      nfQ    <= 1'b0;
    end else begin
      unbalQ <= unbalD;
      suffQ  <= suffD;
      nfQ    <= nfD;
    end
  end

  assign lvl.unbalFlag           = unbalQ;
  assign lvl.sufficientLevelFlag = suffQ;
  assign lvl.nonFaultLevelFlag   = nfQ;

endmodule : cub_level

/* hw/cub_top.sv */
// current unbalance protection: settings, start, delay, trip, events
`include "cub_cfg.svh"

module cub_top
  import cub_pkg::*;
#(
  parameter int CUR_W      = 16,
  parameter int CYC_PER_MS = `CUB_MS_NS / `CUB_CLK_NS
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [CUR_W-1:0] phase1RmsCurrent,
  input  wire logic [CUR_W-1:0] phase2RmsCurrent,
  input  wire logic [CUR_W-1:0] phase3RmsCurrent,
  input  wire logic [CUR_W-1:0] ratedCurrent,
  input  wire logic             operationOn,
  input  wire logic             startSignalOnly,
  input  wire cub_pct_t         startCurrentPct,
  input  wire cub_ms_t          timeDelayMs,
  input  wire logic             blockInput,
  output logic                  generalStartOut,
  output logic                  generalTripOut,
  output logic                  startOnEvent,
  output logic                  startOffEvent,
  output logic                  tripOnEvent,
  output logic                  tripOffEvent
);
  localparam int PRE_W = $clog2(CYC_PER_MS + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);
  localparam logic [PRE_W-1:0] PRE_LAT  = PRE_W'(`CUB_LAT_CYC);

  // ---------------------------------------------------------------
  // settings range limiting
  // ---------------------------------------------------------------
  function automatic cub_pct_t clampPct(input cub_pct_t v);
    if (v < `CUB_PCT_MIN) begin
      clampPct = `CUB_PCT_MIN;
    end else if (v > `CUB_PCT_MAX) begin
      clampPct = `CUB_PCT_MAX;
    end else begin
      clampPct = v;
    end
  endfunction : clampPct

  function automatic cub_ms_t clampDly(input cub_ms_t v);
    if (v < `CUB_DLY_MIN) begin
      clampDly = `CUB_DLY_MIN;
    end else if (v > `CUB_DLY_MAX) begin
      clampDly = `CUB_DLY_MAX;
    end else begin
      clampDly = v;
    end
  endfunction : clampDly

  // ---------------------------------------------------------------
  // event pulses
  // ---------------------------------------------------------------
  // one helper for all four pulses keeps on and off symmetric
  function automatic logic edgeTo(input logic now,
                                  input logic was,
                                  input logic level);
    edgeTo = (now == level) && (was != level);
  endfunction : edgeTo

  // ---------------------------------------------------------------
  // settings stage
  // ---------------------------------------------------------------
  // settings are held here so that reset puts the function in its
  // default (Off) setup regardless of what drives the ports
  logic     operQ, operD;
  logic     sOnlyQ, sOnlyD;
  cub_pct_t pctQ, pctD;
  cub_ms_t  dlyQ, dlyD;

  always_comb begin
    operD  = operationOn;
    sOnlyD = startSignalOnly;
    pctD   = clampPct(startCurrentPct);
    dlyD   = clampDly(timeDelayMs);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      operQ  <= `CUB_OPER_DEF;
      sOnlyQ <= `CUB_SONLY_DEF;
      pctQ   <= `CUB_PCT_DEF;
      dlyQ   <= `CUB_DLY_DEF;
    end else begin
      operQ  <= operD;
      sOnlyQ <= sOnlyD;
      pctQ   <= pctD;
      dlyQ   <= dlyD;
    end
  end

  // ---------------------------------------------------------------
  // analogue stage
  // ---------------------------------------------------------------
  cub_lvl_if lvl ();

  cub_level #(
    .CUR_W (CUR_W)
  ) uLevel (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .phase1RmsCurrent (phase1RmsCurrent),
    .phase2RmsCurrent (phase2RmsCurrent),
    .phase3RmsCurrent (phase3RmsCurrent),
    .ratedCurrent     (ratedCurrent),
    .startPct         (pctQ),
    .lvl              (lvl)
  );

  // ---------------------------------------------------------------
  // decision logic
  // ---------------------------------------------------------------
  logic             enabled;
  logic             startCond;
  cub_state_t       stateQ, stateD;
  logic [PRE_W-1:0] preQ, preD;
  cub_ms_t          msQ, msD;
  logic             startQ, startD;
  logic             tripQ, tripD;
  logic             stOnQ, stOnD, stOffQ, stOffD;
  logic             trOnQ, trOnD, trOffQ, trOffD;

  always_comb begin
    // block is not registered, so it silences one edge before Off
    enabled   = operQ && !blockInput;
    startCond = enabled && lvl.unbalFlag && lvl.sufficientLevelFlag
                && lvl.nonFaultLevelFlag;
    stateD = stateQ;
    preD   = preQ;
    msD    = msQ;
    startD = startCond;
    tripD  = 1'b0;
    if (!startCond) begin
      stateD = CUB_IDLE;
      preD   = '0;
      msD    = '0;
    end else begin
      case (stateQ)
        CUB_IDLE: begin
          // the flags already lag the currents; preload that lag
          stateD = CUB_TIMING;
          preD   = PRE_LAT;
          msD    = '0;
        end
        CUB_TIMING: begin
          // prescaler wraps once per millisecond of delay
          if (preQ >= PRE_LAST) begin
            preD = '0;
            msD  = msQ + 16'h0001;
          end else begin
            preD = preQ + PRE_W'(1);
          end
          if (msD >= dlyQ) begin
            stateD = CUB_TRIPPED;
          end
        end
        CUB_TRIPPED: begin
          // held until the start condition drops
          stateD = CUB_TRIPPED;
        end
        default: begin
          stateD = CUB_IDLE;
        end
      endcase
      // start-only masks trip only; clearing it trips at once
      tripD = (stateD == CUB_TRIPPED) && !sOnlyQ;
    end
    stOnD  = edgeTo(startD, startQ, 1'b1);
    stOffD = edgeTo(startD, startQ, 1'b0);
    trOnD  = edgeTo(tripD, tripQ, 1'b1);
    trOffD = edgeTo(tripD, tripQ, 1'b0);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stateQ <= CUB_IDLE;
      preQ   <= '0;
      msQ    <= '0;
      startQ <= 1'b0;
      tripQ  <= 1'b0;
      stOnQ  <= 1'b0;
      stOffQ <= 1'b0;
      trOnQ  <= 1'b0;
      trOffQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      preQ   <= preD;
      msQ    <= msD;
      startQ <= startD;
      tripQ  <= tripD;
      stOnQ  <= stOnD;
      stOffQ <= stOffD;
      trOnQ  <= trOnD;
      trOffQ <= trOffD;
    end
  end

  assign generalStartOut = startQ;
  assign generalTripOut  = tripQ;
  assign startOnEvent    = stOnQ;
  assign startOffEvent   = stOffQ;
  assign tripOnEvent     = trOnQ;
  assign tripOffEvent    = trOffQ;

endmodule : cub_top

/* testbench/cub_props.sv */
// checker of the current unbalance protection outputs
`include "cub_cfg.svh"
module cub_props
  import cub_pkg::*;
#(
  parameter int CUR_W      = 16,
  parameter int CYC_PER_MS = 10
) (
  input wire logic             mclk,
  input wire logic             sys_rst,
  input wire logic [CUR_W-1:0] phase1RmsCurrent,
  input wire logic [CUR_W-1:0] phase2RmsCurrent,
  input wire logic [CUR_W-1:0] phase3RmsCurrent,
  input wire logic [CUR_W-1:0] ratedCurrent,
  input wire logic             operationOn,
  input wire logic             startSignalOnly,
  input wire cub_pct_t         startCurrentPct,
  input wire cub_ms_t          timeDelayMs,
  input wire logic             blockInput,
  input wire logic             generalStartOut,
  input wire logic             generalTripOut,
  input wire logic             startOnEvent,
  input wire logic             startOffEvent,
  input wire logic             tripOnEvent,
  input wire logic             tripOffEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  // trip may not come before the shortest delay; slack covers latency
  localparam int MIN_HI = int'(`CUB_DLY_MIN) * CYC_PER_MS - 4;
  int unsigned      hiCnt;
  always_ff @(posedge mclk) begin
    if (sys_rst || !generalStartOut) begin
      hiCnt <= 0;
    end else begin
      hiCnt <= hiCnt + 1;
    end
  end
  logic [CUR_W-1:0] maxCur;
  always_comb begin
    maxCur = phase1RmsCurrent;
    if (phase2RmsCurrent > maxCur) maxCur = phase2RmsCurrent;
    if (phase3RmsCurrent > maxCur) maxCur = phase3RmsCurrent;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_off;
    (!operationOn)[*2] |=> !generalStartOut && !generalTripOut;
  endproperty
  a_off: assert property (p_off) else $error("output while off");
  property p_blk;
    blockInput |=> !generalStartOut && !generalTripOut;
  endproperty
  a_blk: assert property (p_blk) else $error("output while blocked");
  property p_sonly;
    startSignalOnly[*2] |=> !generalTripOut;
  endproperty
  a_sonly: assert property (p_sonly) else $error("trip in start only");
  property p_trst;
    generalTripOut |-> generalStartOut;
  endproperty
  a_trst: assert property (p_trst) else $error("trip without start");
  property p_late;
    $rose(generalTripOut) |-> hiCnt >= MIN_HI;
  endproperty
  a_late: assert property (p_late) else $error("trip too early");
  property p_stev;
    startOnEvent == $rose(generalStartOut)
      && startOffEvent == $fell(generalStartOut);
  endproperty
  a_stev: assert property (p_stev) else $error("start event wrong");
  property p_trev;
    tripOnEvent == $rose(generalTripOut)
      && tripOffEvent == $fell(generalTripOut);
  endproperty
  a_trev: assert property (p_trev) else $error("trip event wrong");
  property p_low;
    (32'(maxCur) * 10 <= 32'(ratedCurrent))[*3] |-> !generalStartOut;
  endproperty
  a_low: assert property (p_low) else $error("start at low level");
  property p_high;
    (32'(maxCur) * 2 >= 32'(ratedCurrent) * 3)[*3] |-> !generalStartOut;
  endproperty
  a_high: assert property (p_high) else $error("start at fault level");
  c_start: cover property ($rose(generalStartOut));
  c_trip:  cover property ($rose(generalTripOut));
  c_blk:   cover property (blockInput && generalStartOut);
endmodule : cub_props

bind cub_top cub_props #(.CUR_W(CUR_W), .CYC_PER_MS(CYC_PER_MS)) i_props (.*);

/* testbench/cub_fourier_model.sv */
// rms source standing in for the fourier stage
module cub_fourier_model #(
  parameter int CUR_W = 16
) (
  input  wire logic        mclk,
  output logic [CUR_W-1:0] phase1,
  output logic [CUR_W-1:0] phase2,
  output logic [CUR_W-1:0] phase3
);
  timeunit 1ns;
  timeprecision 1ns;
  // lag lets a scenario present new values slowly
  task automatic put(input logic [CUR_W-1:0] a, b, c, input int lag);
    repeat (lag + 1) @(posedge mclk);
    phase1 <= a;
    phase2 <= b;
    phase3 <= c;
  endtask : put
  initial begin
    phase1 = '0;
    phase2 = '0;
    phase3 = '0;
  end
endmodule : cub_fourier_model

/* testbench/tb_top.sv */
// self-checking bench of the current unbalance protection block
module tb_top
  import cub_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, sysRst, operOn, startOnly, blockIn;
  logic [15:0] p1, p2, p3, rated;
  cub_pct_t    startPct;
  cub_ms_t     delayMs;
  logic        startOut, tripOut, stOn, stOff, trOn, trOff;
  int          bad_count, checked;
  logic [63:0] cases [12] = '{
    64'h03E8_01F4_03E8_32_00, 64'h01F3_03E8_03E8_32_01,
    64'h03E8_03E8_01F3_32_01, 64'h01F3_03E8_01F3_32_01,
    64'h0064_0028_0064_32_00, 64'h0065_0028_0065_32_01,
    64'h05DC_0064_05DC_32_00, 64'h05DB_0064_05DB_32_01,
    64'h03E8_0352_03E8_0A_01, 64'h03E8_0064_03E8_5A_00,
    64'h03E8_0063_03E8_5A_01, 64'h03E8_0398_03E8_05_00};
  always #5 mclk = ~mclk;
  cub_fourier_model #(.CUR_W(16)) i_src (
    .mclk(mclk), .phase1(p1), .phase2(p2), .phase3(p3));
  cub_top #(.CUR_W(16), .CYC_PER_MS(10)) i_dut (
    .mclk(mclk), .sys_rst(sysRst), .phase1RmsCurrent(p1),
    .phase2RmsCurrent(p2), .phase3RmsCurrent(p3), .ratedCurrent(rated),
    .operationOn(operOn), .startSignalOnly(startOnly),
    .startCurrentPct(startPct), .timeDelayMs(delayMs),
    .blockInput(blockIn), .generalStartOut(startOut),
    .generalTripOut(tripOut), .startOnEvent(stOn), .startOffEvent(stOff),
    .tripOnEvent(trOn), .tripOffEvent(trOff));
  task automatic chk(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic outs(input logic st, tr);
    chk({14'h0, startOut, tripOut}, {14'h0, st, tr});
  endtask : outs
  // count edges from fault onset to trip
  task automatic trip_time(input cub_ms_t ms, input int expc);
    int n;
    @(posedge mclk);
    delayMs <= ms;
    i_src.put(16'h03E8, 16'h03E8, 16'h03E8, 0);
    cyc(4);
    i_src.put(16'h03E8, 16'h0190, 16'h03E8, 0);
    n = 0;
    while (tripOut !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(n > expc - 4 && n < expc + 4), 16'h1);
    chk({15'h0, trOn}, 16'h1);
  endtask : trip_time
  initial begin
    logic [15:0] a, b, c;
    logic [7:0]  pc, ex;
    mclk = 0; sysRst = 1; operOn = 0; startOnly = 0; blockIn = 0;
    rated = 16'h03E8; startPct = 7'h32; delayMs = 16'h03E8;
    bad_count = 0; checked = 0;
    cyc(3);
    sysRst <= 0;
    i_src.put(16'h03E8, 16'h0190, 16'h03E8, 2);
    cyc(6); #1;
    outs(1'b0, 1'b0);
    @(posedge mclk);
    operOn <= 1;
    foreach (cases[i]) begin
      {a, b, c, pc, ex} = cases[i];
      @(posedge mclk);
      startPct <= pc[6:0];
      i_src.put(a, b, c, 0);
      cyc(4); #1;
      chk({15'h0, startOut}, {8'h0, ex});
      i_src.put(16'h03E8, 16'h03E8, 16'h03E8, 0);
      cyc(3);
    end
    trip_time(16'h0032, 1000);
    i_src.put(16'h03E8, 16'h03E8, 16'h03E8, 0);
    cyc(2); #1;
    outs(1'b0, 1'b0);
    chk({14'h0, stOff, trOff}, 16'h0003);
    trip_time(16'h0078, 1200);
    @(posedge mclk);
    blockIn <= 1;
    cyc(2); #1;
    outs(1'b0, 1'b0);
    @(posedge mclk);
    blockIn <= 0;
    cyc(4); #1;
    outs(1'b1, 1'b0);
    @(posedge mclk);
    startOnly <= 1;
    cyc(1300); #1;
    outs(1'b1, 1'b0);
    @(posedge mclk);
    operOn <= 0;
    cyc(3); #1;
    outs(1'b0, 1'b0);
    print_verdict();
  end
  initial begin
    #200us;
    bad_count++;
    print_verdict();
  end
endmodule : tb_top
